// ---- ledsc_pkg.sv ----
`default_nettype none
package ledsc_pkg;
  // Display geometry and word layout.
  localparam int DIGITS = 8;
  localparam int DIG_AW = 3;
  localparam int WORD_W = 8;
  localparam int RAM_AW = 4;
  localparam int SEG_W = 7;

  // Field positions of the input byte.
  localparam int BIT_DP = 7;
  localparam int BIT_SEQ = 7;
  localparam int BIT_SCHEME = 6;
  localparam int BIT_TRANSLATE = 5;
  localparam int BIT_POWER = 4;
  localparam int BIT_BANK = 3;
  localparam int ADDR_MSB = 2;

  // Control register reset values.
  localparam logic RST_HEX = 1'b0;
  localparam logic RST_NODEC = 1'b0;
  localparam logic RST_POWER = 1'b1;
  localparam logic RST_BANKA = 1'b1;

  // Timing: clock, per-digit refresh rate and least inter-digit gap.
  localparam int CLK_HZ = 40_000_000;
  localparam int CLK_PERIOD_NS = 25;
  localparam int SCAN_HZ = 390;
  localparam int SLOT_CYCLES = CLK_HZ / (SCAN_HZ * DIGITS);
  localparam int BLANK_NS = 2000;
  localparam int BLANK_CYCLES = (BLANK_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CNT_W = 16;

  // Scan sequencer states.
  typedef enum logic [0:0] {
    SCAN_LIT = 1'b0,
    SCAN_GAP = 1'b1
  } ledsc_scan_t;

  // Three-level configuration pin as seen by the pad.
  typedef enum logic [1:0] {
    CFG_LOW = 2'b00,
    CFG_FLOAT = 2'b01,
    CFG_HIGH = 2'b10
  } ledsc_cfg_t;
endpackage
`default_nettype wire

// ---- ledsc_ram_if.sv ----
`default_nettype none
interface ledsc_ram_if;
  import ledsc_pkg::*;
  logic wrEn;
  logic [RAM_AW-1:0] wrAddr;
  logic [WORD_W-1:0] wrData;
  logic [RAM_AW-1:0] rdAddr;
  logic [WORD_W-1:0] rdData;

  modport ctrl (output wrEn, output wrAddr, output wrData, output rdAddr,
                input rdData);
  modport mem (input wrEn, input wrAddr, input wrData, input rdAddr,
               output rdData);
endinterface
`default_nettype wire

// ---- ledsc_ram.sv ----
`default_nettype none
module ledsc_ram (
  input wire logic ref_clk,
  ledsc_ram_if.mem ram
);
  import ledsc_pkg::*;

  logic [WORD_W-1:0] mem [2**RAM_AW];

  // Two banks of eight digit words; no reset, contents are software's.
  always_ff @(posedge ref_clk) begin
    if (ram.wrEn) begin
      mem[ram.wrAddr] <= ram.wrData;
    end
  end

  // Registered read port; a write to the same word shows one clock later.
  always_ff @(posedge ref_clk) begin
    ram.rdData <= mem[ram.rdAddr];
  end
endmodule
`default_nettype wire

// ---- ledsc_top.sv ----
`default_nettype none
// Notes on behaviour
// - Mode high writes control, low writes RAM.
// - RAM write: line6 is bit7, line5 bit6.
// - RAM write: line7 is bit8, decimal point.
// - Control line6 high hex, low Code B.
// - Control line5 high raw segments, low decoded.
// - Control line7 high announces sequential data.
// - Byte captured on strobe rising edge.
// - Control line4 low shuts down and blanks.
// - No sequence: lines2..0 give single digit address.
// - Control line3 picks bank A high, B low; raw segment mode always uses bank A.
// - Each digit refreshed at 390 Hz.
// - At least 2 us blank between digits.
// - Random variant: three-level pin sets mode.
// - Separate outputs for segments and point.
module ledsc_top #(
  parameter bit RANDOM_ACCESS = 1'b0,
  parameter int SLOT_LEN = ledsc_pkg::SLOT_CYCLES,
  parameter int BLANK_LEN = ledsc_pkg::BLANK_CYCLES
) (
  input wire logic ref_clk,
  input wire logic rst_b,
  input wire logic [7:0] inLine,
  input wire logic modeSel,
  input wire logic writeStrobe,
  input wire logic [ledsc_pkg::DIG_AW-1:0] digitAddrIn,
  input wire ledsc_pkg::ledsc_cfg_t cfgLevel,
  output logic [ledsc_pkg::DIGITS-1:0] digitOut,
  output logic segmentOutA,
  output logic segmentOutB,
  output logic segmentOutC,
  output logic segmentOutD,
  output logic segmentOutE,
  output logic segmentOutF,
  output logic segmentOutG,
  output logic pointSegmentOut,
  output logic shutdownActive
);
  import ledsc_pkg::*;

  localparam int SYNC_W = 15;
  localparam logic [CNT_W-1:0] LIT_LAST = CNT_W'(SLOT_LEN - BLANK_LEN - 1);
  localparam logic [CNT_W-1:0] GAP_LAST = CNT_W'(BLANK_LEN - 1);

  // Code B glyphs: digits, dash, E, H, L, P, blank; order {a..g}.
  function automatic logic [SEG_W-1:0] codeBGlyph(input logic [3:0] n);
    case (n)
      4'h0: codeBGlyph = 7'h7e;
      4'h1: codeBGlyph = 7'h30;
      4'h2: codeBGlyph = 7'h6d;
      4'h3: codeBGlyph = 7'h79;
      4'h4: codeBGlyph = 7'h33;
      4'h5: codeBGlyph = 7'h5b;
      4'h6: codeBGlyph = 7'h5f;
      4'h7: codeBGlyph = 7'h70;
      4'h8: codeBGlyph = 7'h7f;
      4'h9: codeBGlyph = 7'h7b;
      4'ha: codeBGlyph = 7'h01;
      4'hb: codeBGlyph = 7'h4f;
      4'hc: codeBGlyph = 7'h37;
      4'hd: codeBGlyph = 7'h0e;
      4'he: codeBGlyph = 7'h67;
      default: codeBGlyph = 7'h00;
    endcase
  endfunction

  // Hexadecimal glyphs; 0-9 shared with Code B.
  function automatic logic [SEG_W-1:0] hexGlyph(input logic [3:0] n);
    case (n)
      4'ha: hexGlyph = 7'h77;
      4'hb: hexGlyph = 7'h1f;
      4'hc: hexGlyph = 7'h4e;
      4'hd: hexGlyph = 7'h3d;
      4'he: hexGlyph = 7'h4f;
      4'hf: hexGlyph = 7'h47;
      default: hexGlyph = codeBGlyph(n);
    endcase
  endfunction

  ledsc_ram_if ramBus ();

  ledsc_ram u_ram (
    .ref_clk(ref_clk),
    .ram(ramBus.mem)
  );

  logic [SYNC_W-1:0] syncA_q;
  logic [SYNC_W-1:0] syncB_q;
  logic [SYNC_W-1:0] prev_q;

  // Pins pass two flops; a third copy holds the sample before the edge.
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      syncA_q <= '0;
      syncB_q <= '0;
      prev_q <= '0;
    end else begin
      syncA_q <= {writeStrobe, modeSel, inLine, digitAddrIn, cfgLevel};
      syncB_q <= syncA_q;
      prev_q <= syncB_q;
    end
  end

  // Data and mode come from the sample taken while the strobe was still low,
  // so zero hold time at the pins is safe.
  logic strobeRise;
  logic modeHeld;
  logic [7:0] dataHeld;
  logic [DIG_AW-1:0] addrHeld;
  ledsc_cfg_t cfgNow;
  assign strobeRise = syncB_q[14] & ~prev_q[14];
  assign modeHeld = prev_q[13];
  assign dataHeld = prev_q[12:5];
  assign addrHeld = prev_q[4:2];
  assign cfgNow = ledsc_cfg_t'(syncB_q[1:0]);

  logic hex_q;
  logic noDec_q;
  logic powerOn_q;
  logic bankA_q;
  logic seqActive_q;
  logic [DIG_AW:0] seqCount_q;
  logic [DIG_AW-1:0] singleAddr_q;
  logic ctrlWrite;
  logic ramWrite;
  assign ctrlWrite = strobeRise & modeHeld & ~RANDOM_ACCESS;
  assign ramWrite = strobeRise & (~modeHeld | RANDOM_ACCESS);

  // Control register fields.
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      hex_q <= RST_HEX;
      noDec_q <= RST_NODEC;
      powerOn_q <= RST_POWER;
      bankA_q <= RST_BANKA;
      singleAddr_q <= '0;
    end else if (ctrlWrite) begin
      hex_q <= dataHeld[BIT_SCHEME];
      noDec_q <= dataHeld[BIT_TRANSLATE];
      powerOn_q <= dataHeld[BIT_POWER];
      bankA_q <= dataHeld[BIT_BANK];
      if (!dataHeld[BIT_SEQ]) begin
        singleAddr_q <= dataHeld[ADDR_MSB:0];
      end
    end
  end

  // Sequential loading: a control write restarts the count at digit zero.
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      seqActive_q <= 1'b0;
      seqCount_q <= '0;
    end else if (ctrlWrite) begin
      seqActive_q <= dataHeld[BIT_SEQ];
      seqCount_q <= '0;
    end else if (ramWrite && seqActive_q) begin
      seqCount_q <= seqCount_q + 1'b1;
      if (seqCount_q == (DIG_AW+1)'(DIGITS - 1)) begin
        seqActive_q <= 1'b0;
      end
    end
  end

  // Settings in force, either from the register or the three-level pin.
  logic effHex;
  logic effNoDec;
  logic effOn;
  logic bankSel;
  always_comb begin
    if (RANDOM_ACCESS) begin
      effHex = (cfgNow == CFG_HIGH);
      effNoDec = 1'b0;
      effOn = (cfgNow != CFG_LOW);
      bankSel = 1'b0;
    end else begin
      effHex = hex_q;
      effNoDec = noDec_q;
      effOn = powerOn_q;
      bankSel = noDec_q ? 1'b0 : ~bankA_q;
    end
  end

  // The byte maps straight into the word: line7 is the point, line6/5 the
  // top data bits, so no shuffling is needed.
  logic [DIG_AW-1:0] wrDigit;
  always_comb begin
    if (RANDOM_ACCESS) begin
      wrDigit = addrHeld;
    end else if (seqActive_q) begin
      wrDigit = seqCount_q[DIG_AW-1:0];
    end else begin
      wrDigit = singleAddr_q;
    end
  end
  assign ramBus.wrEn = ramWrite;
  assign ramBus.wrAddr = {bankSel, wrDigit};
  assign ramBus.wrData = dataHeld;

  ledsc_scan_t state_q;
  logic [CNT_W-1:0] cnt_q;
  logic [DIG_AW-1:0] digit_q;
  logic [DIG_AW-1:0] nextDigit;
  assign nextDigit = digit_q + 1'b1;
  assign ramBus.rdAddr = {bankSel, nextDigit};

  // Scan sequencer: lit slot then a blank gap; the gap keeps drives apart.
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      state_q <= SCAN_GAP;
      cnt_q <= '0;
      digit_q <= '1;
    end else if (!effOn) begin
      state_q <= SCAN_GAP;
      cnt_q <= '0;
    end else begin
      case (state_q)
        SCAN_LIT: begin
          if (cnt_q == LIT_LAST) begin
            state_q <= SCAN_GAP;
            cnt_q <= '0;
          end else begin
            cnt_q <= cnt_q + 1'b1;
          end
        end
        SCAN_GAP: begin
          if (cnt_q == GAP_LAST) begin
            state_q <= SCAN_LIT;
            cnt_q <= '0;
            digit_q <= nextDigit;
          end else begin
            cnt_q <= cnt_q + 1'b1;
          end
        end
        default: begin
          state_q <= SCAN_GAP;
          cnt_q <= '0;
        end
      endcase
    end
  end

  // Decoded or raw image of the word for the coming digit.
  logic [SEG_W-1:0] segNext;
  always_comb begin
    if (effNoDec) begin
      segNext = ramBus.rdData[SEG_W-1:0];
    end else if (effHex) begin
      segNext = hexGlyph(ramBus.rdData[3:0]);
    end else begin
      segNext = codeBGlyph(ramBus.rdData[3:0]);
    end
  end

  logic gapEnd;
  assign gapEnd = effOn && state_q == SCAN_GAP && cnt_q == GAP_LAST;

  // Output drives; segments change only in shutdown or on the edge that lights a digit.
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      digitOut <= '0;
      {segmentOutA, segmentOutB, segmentOutC, segmentOutD} <= 4'h0;
      {segmentOutE, segmentOutF, segmentOutG, pointSegmentOut} <= 4'h0;
      shutdownActive <= 1'b0;
    end else begin
      shutdownActive <= ~effOn;
      if (!effOn || (state_q == SCAN_LIT && cnt_q == LIT_LAST)) begin
        digitOut <= '0;
        if (!effOn) begin
          {segmentOutA, segmentOutB, segmentOutC, segmentOutD} <= 4'h0;
          {segmentOutE, segmentOutF, segmentOutG, pointSegmentOut} <= 4'h0;
        end
      end else if (gapEnd) begin
        digitOut <= DIGITS'(1) << nextDigit;
        {segmentOutA, segmentOutB, segmentOutC, segmentOutD,
         segmentOutE, segmentOutF, segmentOutG} <= segNext;
        pointSegmentOut <= ramBus.rdData[BIT_DP];
      end
    end
  end
endmodule
`default_nettype wire

// ---- ledsc_top_end.sv ----
`default_nettype none
`default_nettype wire

// ---- ledsc_host_model.sv ----
`default_nettype none
module ledsc_host_model (
  output var logic [7:0] inLine,
  output var logic modeSel,
  output var logic writeStrobe,
  input wire logic ref_clk
);
  // The bus starts idle with the strobe low.
  initial begin
    inLine = 8'h00;
    modeSel = 1'b0;
    writeStrobe = 1'b0;
  end

  // One write: byte and target settle four cycles before the strobe rises
  // and hold while it is high and four cycles after it falls; then the bus inverts them.
  task automatic put(input logic mode, input logic [7:0] data);
    @(posedge ref_clk);
    inLine <= data;
    modeSel <= mode;
    repeat (4) @(posedge ref_clk);
    writeStrobe <= 1'b1;
    repeat (4) @(posedge ref_clk);
    writeStrobe <= 1'b0;
    repeat (4) @(posedge ref_clk);
    inLine <= ~data;
    modeSel <= ~mode;
  endtask
endmodule
`default_nettype wire

// ---- ledsc_top_chk.sv ----
`default_nettype none
module ledsc_top_chk #(
  parameter int SLOT_LEN = 40,
  parameter int BLANK_LEN = 8
) (
  input wire logic ref_clk,
  input wire logic rst_b,
  input wire logic [7:0] inLine,
  input wire logic modeSel,
  input wire logic writeStrobe,
  input wire logic [ledsc_pkg::DIG_AW-1:0] digitAddrIn,
  input wire ledsc_pkg::ledsc_cfg_t cfgLevel,
  input wire logic [ledsc_pkg::DIGITS-1:0] digitOut,
  input wire logic segmentOutA,
  input wire logic segmentOutB,
  input wire logic segmentOutC,
  input wire logic segmentOutD,
  input wire logic segmentOutE,
  input wire logic segmentOutF,
  input wire logic segmentOutG,
  input wire logic pointSegmentOut,
  input wire logic shutdownActive
);
  import ledsc_pkg::*;
  logic [15:0] gapQ;
  logic [15:0] litQ;
  logic [7:0] lastQ;
  logic [7:0] segs;
  assign segs = {pointSegmentOut, segmentOutA, segmentOutB, segmentOutC,
                 segmentOutD, segmentOutE, segmentOutF, segmentOutG};
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_b);

  // Run lengths of dark and lit stretches; the dark one saturates.
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      gapQ <= 16'h0;
      litQ <= 16'h0;
    end else begin
      gapQ <= (digitOut != 0) ? 16'h0 : gapQ + {15'h0, gapQ != 16'hffff};
      litQ <= (digitOut == 0) ? 16'h0 : litQ + 16'h1;
    end
  end

  // Last lit digit; forgotten in shutdown, since wake-up order is free.
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      lastQ <= 8'h0;
    end else if (shutdownActive) begin
      lastQ <= 8'h0;
    end else if (digitOut != 0) begin
      lastQ <= digitOut;
    end
  end

  a_digit_onehot: assert property ($onehot0(digitOut))
    else $error("digit drives overlap");
  a_gap_long: assert property ($rose(|digitOut) |-> gapQ >= BLANK_LEN)
    else $error("blank gap too short");
  a_lit_not_long: assert property (litQ <= SLOT_LEN - BLANK_LEN)
    else $error("digit lit too long");
  a_digit_order: assert property ($rose(|digitOut) && lastQ != 0
    |-> digitOut == {lastQ[6:0], lastQ[7]})
    else $error("digits out of order");
  a_sleep_entry: assert property ($rose(writeStrobe) && modeSel
    && !inLine[4] |-> ##[1:6] shutdownActive)
    else $error("shutdown not entered");
  a_sleep_exit: assert property ($rose(writeStrobe) && modeSel
    && inLine[4] |-> ##[1:6] !shutdownActive)
    else $error("shutdown not left");
  a_sleep_dark: assert property (shutdownActive && $past(shutdownActive)
    |-> digitOut == 0 && segs == 0)
    else $error("display lit in shutdown");
  a_segs_hold: assert property (digitOut != 0 && $stable(digitOut)
    |-> $stable(segs))
    else $error("segments moved within a slot");
endmodule
bind ledsc_top ledsc_top_chk #(.SLOT_LEN(SLOT_LEN), .BLANK_LEN(BLANK_LEN))
  i_ledsc_top_chk (.*);
`default_nettype wire

// ---- tb_led_display_write_and_scan.sv ----
`default_nettype none
module tb_led_display_write_and_scan;
  timeunit 1ns;
  timeprecision 100ps;
  import ledsc_pkg::*;
  logic ref_clk = 1'b0;
  logic rst_b = 1'b0;
  logic [7:0] inLine;
  logic [7:0] digitOut;
  logic modeSel, writeStrobe, sA, sB, sC, sD, sE, sF, sG, sP, sleep;
  int n_errors = 0;
  int n_tests = 0;

  ledsc_host_model i_ledsc_host_model (.inLine(inLine), .modeSel(modeSel),
    .writeStrobe(writeStrobe), .ref_clk(ref_clk));
  // The gap keeps its full length; only the lit part of a slot is short.
  ledsc_top #(.SLOT_LEN(120), .BLANK_LEN(80)) i_ledsc_top (
    .ref_clk(ref_clk), .rst_b(rst_b), .inLine(inLine), .modeSel(modeSel),
    .writeStrobe(writeStrobe), .digitAddrIn(3'h0), .cfgLevel(CFG_HIGH),
    .digitOut(digitOut), .segmentOutA(sA), .segmentOutB(sB),
    .segmentOutC(sC), .segmentOutD(sD), .segmentOutE(sE),
    .segmentOutF(sF), .segmentOutG(sG), .pointSegmentOut(sP),
    .shutdownActive(sleep));

  initial begin
    forever #12.5 ref_clk = ~ref_clk;
  end

  task automatic report_and_stop();
    $display("comparisons %0d mismatches %0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  task automatic cmp(input logic [7:0] got, input logic [7:0] exp);
    n_tests++;
    if (got !== exp) begin
      n_errors++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask

  // Waits for digit k to light afresh, so new data has had a slot start.
  task automatic see(input int k, input logic [7:0] exp);
    int n;
    n = 0;
    // Step off the launching edge before the first look at the outputs.
    @(negedge ref_clk);
    while (digitOut[k] === 1'b1 && n < 4000) begin
      @(negedge ref_clk);
      n++;
    end
    while (digitOut[k] !== 1'b1 && n < 4000) begin
      @(negedge ref_clk);
      n++;
    end
    if (n >= 4000) begin
      n_errors++;
      report_and_stop();
    end
    cmp({sP, sA, sB, sC, sD, sE, sF, sG}, exp);
  endtask

  task automatic t_seq();
    i_ledsc_host_model.put(1'b1, 8'hb8);
    for (int i = 0; i < 8; i++) begin
      i_ledsc_host_model.put(1'b0, 8'h80 ^ (8'h01 << i));
    end
    i_ledsc_host_model.put(1'b0, 8'h7f);
    for (int k = 1; k < 8; k++) begin
      see(k, 8'h80 ^ (8'h01 << k));
    end
    see(0, 8'h7f);
    $display("sequential load done");
  endtask

  task automatic t_single();
    i_ledsc_host_model.put(1'b1, 8'h3d);
    i_ledsc_host_model.put(1'b0, 8'h5a);
    see(5, 8'h5a);
    see(4, 8'h90);
    $display("single digit done");
  endtask

  task automatic t_decode();
    i_ledsc_host_model.put(1'b1, 8'h50);
    i_ledsc_host_model.put(1'b0, 8'h08);
    see(0, 8'h7f);
    i_ledsc_host_model.put(1'b1, 8'h58);
    i_ledsc_host_model.put(1'b0, 8'h8a);
    see(0, 8'hf7);
    i_ledsc_host_model.put(1'b1, 8'h18);
    see(0, 8'h81);
    i_ledsc_host_model.put(1'b1, 8'h50);
    see(0, 8'h7f);
    $display("decode and banks done");
  endtask

  task automatic t_sleep();
    i_ledsc_host_model.put(1'b1, 8'h28);
    @(negedge ref_clk);
    cmp(digitOut, 8'h00);
    cmp({7'h0, sleep}, 8'h01);
    i_ledsc_host_model.put(1'b1, 8'h38);
    see(5, 8'h5a);
    $display("shutdown done");
  endtask

  initial begin
    repeat (6) @(posedge ref_clk);
    rst_b <= 1'b1;
    t_seq();
    t_single();
    t_decode();
    t_sleep();
    report_and_stop();
  end
endmodule
`default_nettype wire
